// >>> design/rior_map.vh
`ifndef RIOR_MAP_VH
`define RIOR_MAP_VH
// Remote input word fields
`define RIOR_OPSEL_LSB 0
`define RIOR_START_BIT 3
`define RIOR_HOME_BIT 4
`define RIOR_STOP_BIT 5
`define RIOR_FREE_BIT 6
`define RIOR_PICK_LSB 8
`define RIOR_DGO_BIT 11
`define RIOR_INCHP_BIT 12
`define RIOR_INCHN_BIT 13
`define RIOR_FWD_BIT 14
`define RIOR_RVS_BIT 15
// Command field
`define RIOR_REQ_BIT 14
`define RIOR_CODE_MASK 16'hbfff
`define RIOR_CMD_POS1_WR 16'h1201
`define RIOR_CMD_MON_FBSPD 16'h2067
`define RIOR_WR_ENTRY 1
// Response status bits
`define RIOR_ST_ACK_BIT 0
`define RIOR_ST_BUSY_BIT 1
`define RIOR_ST_AXERR_BIT 2
`define RIOR_ST_CMDERR_BIT 3
`define RIOR_DATA_W 32
`define RIOR_NENTRY 8
`endif

// >>> design/rior_core.v
`timescale 1ns/1ps
// Operation
// RULE1: Low input byte decodes select, start, home, stop, free
// RULE2: High byte decodes pick, direct go, jog, run
// RULE3: Select plus start rising begins positioning
// RULE4: Forward run level drives forward continuous motion
// RULE5: Bit 14 of command field is request
// RULE6: Write request stores data then raises acknowledge
// RULE7: Master waits acknowledge, then writes zero
// RULE8: Code 1201h writes entry 1 position
// RULE9: Code 2067h monitors speed while requested
// RULE10: Monitored values go to response data
// RULE11: Writes volatile; save only on batch command
// RULE12: One monitor item; change address first
// RULE13: Network error lights network indicator
// RULE14: Serial failure lights link fault indicator
// RULE15: Response echoes code, request and status
// RULE16: Starts on rising edge; runs, jogs level
// RULE17: Acknowledge clears when request returns zero
`include "rior_map.vh"
module rior_core #(
  parameter DW = `RIOR_DATA_W,
  parameter NENTRY = `RIOR_NENTRY
) (
  input wire sys_clk,
  input wire nrst,
  input wire in_valid,
  input wire [15:0] remote_input_word,
  input wire [15:0] reg_addr,
  input wire [15:0] cmd_field,
  input wire [DW-1:0] cmd_data,
  input wire [DW-1:0] feedback_speed,
  input wire batch_save,
  input wire net_error,
  input wire serial_error,
  output reg [2:0] op_select,
  output reg [2:0] direct_pick,
  output reg start_pulse,
  output reg home_pulse,
  output reg direct_go_pulse,
  output reg stop_level,
  output reg free_level,
  output reg inch_positive,
  output reg inch_negative,
  output reg forward_run,
  output reg reverse_run,
  output reg [2:0] pos_entry,
  output reg [DW-1:0] pos_target,
  output reg [15:0] resp_addr,
  output reg [15:0] resp_cmd,
  output reg [7:0] resp_status,
  output reg [DW-1:0] resp_data,
  output reg execute_acknowledge,
  output reg nv_save_pulse,
  output reg [DW-1:0] entry1_saved,
  output reg net_err_led,
  output reg link_activity_fault_led
);
  localparam ST_IDLE = 3'b001;
  localparam ST_MON = 3'b010;
  localparam ST_DONE = 3'b100;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [15:0] prev_in_reg;
  reg [7:0] status_next;
  reg [DW-1:0] op_pos_reg [0:NENTRY-1];
  wire execute_request = cmd_field[`RIOR_REQ_BIT]; // RULE5
  wire [15:0] code = cmd_field & `RIOR_CODE_MASK; // RULE5
  wire is_wr = (code == `RIOR_CMD_POS1_WR); // RULE8
  wire is_mon = (code == `RIOR_CMD_MON_FBSPD); // RULE9
  wire cmd_take = (state_reg == ST_IDLE) && execute_request;
  wire wr_take = cmd_take && is_wr; // RULE6
  wire [15:0] rise = remote_input_word & ~prev_in_reg; // RULE16
  wire [2:0] sel_in = remote_input_word[`RIOR_OPSEL_LSB +: 3];
  genvar g;

  // Only entry 1 has a write code; the other entries keep their reset value
  generate
    for (g = 0; g < NENTRY; g = g + 1) begin : g_entry
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          op_pos_reg[g] <= {DW{1'b0}};
        end else if (wr_take && (g == `RIOR_WR_ENTRY)) begin
          op_pos_reg[g] <= cmd_data; // RULE8 RULE11
        end
      end
    end
  endgenerate

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (execute_request) begin
          state_next = is_mon ? ST_MON : ST_DONE; // RULE6
        end
      end
      ST_MON: begin
        if (!execute_request) begin
          state_next = ST_IDLE; // RULE9
        end
      end
      ST_DONE: begin
        if (!execute_request) begin
          state_next = ST_IDLE; // RULE17
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edge memory resets to the idle level of the word, so no false start follows reset
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prev_in_reg <= 16'h0000;
      op_select <= 3'h0;
      direct_pick <= 3'h0;
      stop_level <= 1'b0;
      free_level <= 1'b0;
      inch_positive <= 1'b0;
      inch_negative <= 1'b0;
      forward_run <= 1'b0;
      reverse_run <= 1'b0;
    end else begin
      // Word sampled once per update; between updates levels hold
      if (in_valid) begin
        prev_in_reg <= remote_input_word;
        op_select <= sel_in; // RULE1
        stop_level <= remote_input_word[`RIOR_STOP_BIT]; // RULE1
        free_level <= remote_input_word[`RIOR_FREE_BIT]; // RULE1
        direct_pick <= remote_input_word[`RIOR_PICK_LSB +: 3]; // RULE2
        inch_positive <= remote_input_word[`RIOR_INCHP_BIT]; // RULE2
        inch_negative <= remote_input_word[`RIOR_INCHN_BIT]; // RULE2
        forward_run <= remote_input_word[`RIOR_FWD_BIT]; // RULE4
        reverse_run <= remote_input_word[`RIOR_RVS_BIT]; // RULE2
      end
    end
  end

  // Starts act on the rising edge only, so a held start bit cannot retrigger
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      start_pulse <= 1'b0;
      home_pulse <= 1'b0;
      direct_go_pulse <= 1'b0;
    end else begin
      start_pulse <= in_valid && rise[`RIOR_START_BIT]; // RULE1 RULE16
      home_pulse <= in_valid && rise[`RIOR_HOME_BIT]; // RULE1 RULE16
      direct_go_pulse <= in_valid && rise[`RIOR_DGO_BIT]; // RULE2 RULE16
    end
  end

  // Entry and position are frozen at the start edge; later select changes do not move it
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pos_entry <= 3'h0;
      pos_target <= {DW{1'b0}};
    end else if (in_valid && rise[`RIOR_START_BIT]) begin
      pos_entry <= sel_in; // RULE3
      pos_target <= op_pos_reg[sel_in]; // RULE3
    end
  end

  always @* begin
    status_next = 8'h00;
    status_next[`RIOR_ST_ACK_BIT] = (state_reg != ST_IDLE); // RULE15
    status_next[`RIOR_ST_BUSY_BIT] = (state_reg == ST_MON); // RULE15
    // No axis fault source in this block; the bit stays clear
    status_next[`RIOR_ST_AXERR_BIT] = 1'b0;
    status_next[`RIOR_ST_CMDERR_BIT] = execute_request && !is_wr && !is_mon; // RULE15
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      resp_addr <= 16'h0000;
      resp_cmd <= 16'h0000;
      resp_status <= 8'h00;
      resp_data <= {DW{1'b0}};
      execute_acknowledge <= 1'b0;
    end else begin
      // Acknowledge one clock after the store, so the data is already in place
      execute_acknowledge <= (state_reg == ST_DONE) || (state_reg == ST_MON); // RULE6 RULE17
      resp_addr <= reg_addr;
      resp_cmd <= cmd_field; // RULE15
      resp_status <= status_next; // RULE15
      if (state_reg == ST_MON) begin
        resp_data <= feedback_speed; // RULE9 RULE10
      end else if (wr_take) begin
        resp_data <= cmd_data;
      end
    end
  end

  // Only an explicit save reaches the backup copy; writes stay volatile
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nv_save_pulse <= 1'b0;
      entry1_saved <= {DW{1'b0}};
    end else begin
      nv_save_pulse <= batch_save; // RULE11
      if (batch_save) begin
        entry1_saved <= op_pos_reg[`RIOR_WR_ENTRY]; // RULE11
      end
    end
  end

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      net_err_led <= 1'b0;
      link_activity_fault_led <= 1'b0;
    end else begin
      net_err_led <= net_error; // RULE13
      link_activity_fault_led <= serial_error; // RULE14
    end
  end
endmodule // rior_core

// >>> tb/rior_assertions.sv
`timescale 1ns/1ps
module rior_chk #(parameter DW = 32) (
  input wire sys_clk,
  input wire nrst,
  input wire in_valid,
  input wire [15:0] remote_input_word,
  input wire [15:0] cmd_field,
  input wire [DW-1:0] feedback_speed,
  input wire batch_save,
  input wire serial_error,
  input wire [2:0] op_select,
  input wire start_pulse,
  input wire execute_acknowledge,
  input wire [15:0] resp_cmd,
  input wire [DW-1:0] resp_data,
  input wire nv_save_pulse,
  input wire link_activity_fault_led
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_start_cause: assert property (start_pulse |-> $past(in_valid && remote_input_word[3]))
    else $error("start pulse without start");
  a_sel_decode: assert property (in_valid |=> op_select == $past(remote_input_word[2:0]))
    else $error("select mismatch");
  a_ack_cause: assert property ($rose(execute_acknowledge) |-> $past(cmd_field[14], 2))
    else $error("ack without request");
  a_ack_clear: assert property (!cmd_field[14] [*3] |-> !execute_acknowledge)
    else $error("ack stuck");
  a_mon_track: assert property ((cmd_field == 16'h6067) [*4] |->
    resp_data == $past(feedback_speed)) else $error("monitor stale");
  a_echo_code: assert property ($stable(cmd_field) [*3] |-> resp_cmd == cmd_field)
    else $error("echo mismatch");
  a_nv_only: assert property (1 |=> nv_save_pulse == $past(batch_save))
    else $error("save pulse wrong");
  a_link_led: assert property (1 |=> link_activity_fault_led == $past(serial_error))
    else $error("link led wrong");
  c_start: cover property (start_pulse);
  c_ack: cover property ($rose(execute_acknowledge));
  c_save: cover property (nv_save_pulse);
endmodule // rior_chk
bind rior_core rior_chk #(.DW(DW)) u_chk (.sys_clk, .nrst, .in_valid, .remote_input_word,
  .cmd_field, .feedback_speed, .batch_save, .serial_error, .op_select, .start_pulse,
  .execute_acknowledge, .resp_cmd, .resp_data, .nv_save_pulse, .link_activity_fault_led);

// >>> tb/rior_master.sv
`timescale 1ns/1ps
module rior_master (
  input wire sys_clk,
  input wire execute_acknowledge,
  output reg [15:0] cmd_field
);
  initial cmd_field = 16'h0000;
  // Bounded wait so a silent driver cannot hang the run
  task issue(input [15:0] code, input integer hold, output bit ok);
    ok = 0;
    @(posedge sys_clk) cmd_field <= code | 16'h4000;
    repeat (20) if (!ok) @(posedge sys_clk) ok = execute_acknowledge;
    repeat (hold) @(posedge sys_clk);
    @(posedge sys_clk) cmd_field <= 16'h0000;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule // rior_master

// >>> tb/tb_rior_core.sv
`timescale 1ns/1ps
module tb_rior_core;
  reg sys_clk = 0, nrst = 0, in_valid = 0, batch_save = 0, net_error = 0, serial_error = 0;
  reg [15:0] remote_input_word = 0, reg_addr = 0;
  reg [31:0] cmd_data = 0, feedback_speed = 32'h0abc;
  wire [15:0] cmd_field, resp_cmd, resp_addr;
  wire [7:0] resp_status;
  wire [2:0] op_select, direct_pick, pos_entry;
  wire [31:0] pos_target, resp_data, entry1_saved;
  wire start_pulse, home_pulse, direct_go_pulse, stop_level, free_level, inch_positive;
  wire inch_negative, forward_run, reverse_run, execute_acknowledge, nv_save_pulse;
  wire net_err_led, link_activity_fault_led;
  wire [15:0] dec = {reverse_run, forward_run, inch_negative, inch_positive, direct_go_pulse,
    direct_pick, 1'b0, free_level, stop_level, home_pulse, start_pulse, op_select};
  integer errors = 0, n_compared = 0, i;
  bit ok;
  rior_master mst (.sys_clk, .execute_acknowledge, .cmd_field);
  rior_core dut_u (.sys_clk, .nrst, .in_valid, .remote_input_word, .reg_addr, .cmd_field,
    .cmd_data, .feedback_speed, .batch_save, .net_error, .serial_error, .op_select,
    .direct_pick, .start_pulse, .home_pulse, .direct_go_pulse, .stop_level, .free_level,
    .inch_positive, .inch_negative, .forward_run, .reverse_run, .pos_entry, .pos_target,
    .resp_addr, .resp_cmd, .resp_status, .resp_data, .execute_acknowledge,
    .nv_save_pulse, .entry1_saved, .net_err_led, .link_activity_fault_led);
  initial forever #2 sys_clk = ~sys_clk;
  task chk(input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task put(input [15:0] w);
    @(posedge sys_clk) begin
      in_valid <= 1;
      remote_input_word <= w;
    end
    @(posedge sys_clk) in_valid <= 0;
    #1;
  endtask
  task cmd(input [15:0] c, input integer h);
    mst.issue(c, h, ok);
    chk(ok, 1);
    if (!ok) give_verdict;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1;
    cmd_data <= 32'h1388;
    cmd(16'h1201, 0);
    chk(entry1_saved, 0);
    put(16'h0009);
    chk({start_pulse, pos_entry}, 4'h9);
    chk(pos_target, 32'h1388);
    for (i = 0; i < 16; i++) begin
      put(16'h1 << i);
      chk(dec, (16'h1 << i) & 16'hff7f);
    end
    @(posedge sys_clk) reg_addr <= 16'h0001;
    fork
      cmd(16'h2067, 12);
      begin
        repeat (6) @(posedge sys_clk);
        feedback_speed <= 32'h0def;
        repeat (4) @(posedge sys_clk);
        #1 chk(resp_data, 32'h0def);
        chk(resp_cmd, 16'h6067);
        chk(resp_status, 8'h03);
        chk(resp_addr, 16'h0001);
      end
    join
    fork
      cmd(16'h0123, 2);
      begin
        repeat (4) @(posedge sys_clk);
        #1 chk(resp_status, 8'h09);
      end
    join
    @(posedge sys_clk) batch_save <= 1;
    @(posedge sys_clk) batch_save <= 0;
    @(posedge sys_clk) #1 chk(entry1_saved, 32'h1388);
    @(posedge sys_clk) {net_error, serial_error} <= 2'b11;
    repeat (2) @(posedge sys_clk);
    #1 chk({net_err_led, link_activity_fault_led}, 2'b11);
    give_verdict;
  end
endmodule // tb_rior_core
